/* stca_consts.svh */
`ifndef STCA_CONSTS_SVH
`define STCA_CONSTS_SVH
// register offsets on the 8-bit io bus
`define STCA_ADR_CNT_L 6'h00
`define STCA_ADR_CNT_H 6'h01
`define STCA_ADR_CMPA_L 6'h02
`define STCA_ADR_CMPA_H 6'h03
`define STCA_ADR_CMPB_L 6'h04
`define STCA_ADR_CMPB_H 6'h05
`define STCA_ADR_CAP_L 6'h06
`define STCA_ADR_CAP_H 6'h07
`define STCA_ADR_CTRL_A 6'h08
`define STCA_ADR_CTRL_B 6'h09
`define STCA_ADR_FLAG 6'h0A
`define STCA_ADR_MASK 6'h0B
`define STCA_ADR_SFIO 6'h0C
// field positions
`define STCA_SFIO_PSR 0
`define STCA_FLG_CAP 5
`define STCA_FLG_CMPA 4
`define STCA_FLG_CMPB 3
`define STCA_FLG_OVF 2
`define STCA_CA_FOCA 3
`define STCA_CA_FOCB 2
`define STCA_CB_NC 7
`define STCA_CB_ES 6
`define STCA_CB_WGM3 4
`define STCA_CB_WGM2 3
// reset values
`define STCA_RST_BYTE 8'h00
`define STCA_RST_WORD 16'h0000
// count boundaries
`define STCA_BOTTOM 16'h0000
`define STCA_MAX 16'hFFFF
`define STCA_TOP8 16'h00FF
`define STCA_TOP9 16'h01FF
`define STCA_TOP10 16'h03FF
// prescaler taps and filter length
`define STCA_PRE_W 10
`define STCA_NC_LEN 4
`endif

/* stca_pkg.sv */
package stca_pkg;
    typedef enum logic [2:0] {
        STCA_CS_OFF, STCA_CS_DIV1, STCA_CS_DIV8, STCA_CS_DIV64,
        STCA_CS_DIV256, STCA_CS_DIV1024, STCA_CS_EXT_FALL, STCA_CS_EXT_RISE
    } stca_cs_t;
endpackage : stca_pkg

/* stca_tick_if.sv */
interface stca_tick_if;
    logic psr_clear;
    logic [2:0] cs;
    logic ext_sync;
    logic tick;
    modport gen (input psr_clear, input cs, input ext_sync, output tick);
    modport user (output psr_clear, output cs, output ext_sync, input tick);
endinterface : stca_tick_if

/* stca_tick_gen.sv */
`include "stca_consts.svh"
module stca_tick_gen (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // tick channel
    stca_tick_if.gen tif
);
    logic [`STCA_PRE_W-1:0] pre_q, pre_d;
    logic ext_prev_q, ext_prev_d;
    logic rise, fall;

    // free-running shared prescaler
    always_comb begin
        pre_d = tif.psr_clear ? '0 : pre_q + 1'b1;
        ext_prev_d = tif.ext_sync;
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            pre_q <= '0;
            ext_prev_q <= 1'b0;
        end else begin
            pre_q <= pre_d;
            ext_prev_q <= ext_prev_d;
        end
    end

    assign rise = tif.ext_sync & ~ext_prev_q;
    assign fall = ~tif.ext_sync & ext_prev_q;

    // clock source select and taps
    always_comb begin
        case (stca_pkg::stca_cs_t'(tif.cs))
            stca_pkg::STCA_CS_OFF: tif.tick = 1'b0;
            stca_pkg::STCA_CS_DIV1: tif.tick = 1'b1;
            stca_pkg::STCA_CS_DIV8: tif.tick = &pre_q[2:0];
            stca_pkg::STCA_CS_DIV64: tif.tick = &pre_q[5:0];
            stca_pkg::STCA_CS_DIV256: tif.tick = &pre_q[7:0];
            stca_pkg::STCA_CS_DIV1024: tif.tick = &pre_q[9:0];
            stca_pkg::STCA_CS_EXT_FALL: tif.tick = fall;
            stca_pkg::STCA_CS_EXT_RISE: tif.tick = rise;
            default: tif.tick = 1'b0;
        endcase
    end

    a_off_no_tick: assert property (@(posedge clk) disable iff (!reset_n)
        tif.cs == 3'h0 |-> !tif.tick) else $error("tick while stopped");
    a_div8_period: assert property (@(posedge clk) disable iff (!reset_n)
        (tif.cs == 3'h2 && tif.tick && !tif.psr_clear) ##1 (tif.cs == 3'h2 && !tif.psr_clear)[*7]
        |-> !$past(tif.tick)) else $error("div8 tick spacing wrong");
    a_psr_zero: assert property (@(posedge clk) disable iff (!reset_n)
        tif.psr_clear |=> pre_q == '0) else $error("prescaler not cleared");
endmodule : stca_tick_gen

/* stca_timer.sv */
`include "stca_consts.svh"
module stca_timer (
    // clock and reset
    input wire logic clk,
    input wire logic reset_n,
    // processor io bus
    input wire logic [5:0] io_addr,
    input wire logic io_wr,
    input wire logic io_rd,
    input wire logic [7:0] io_wdata,
    output logic [7:0] io_rdata,
    // pins and comparator
    input wire logic external_count_pin,
    input wire logic capture_input_pin,
    input wire logic comparator_out,
    // compare results toward waveform logic
    output logic match_a,
    output logic match_b,
    output logic at_bottom,
    output logic at_max,
    output logic at_top,
    // interrupt requests
    output logic irq_overflow,
    output logic irq_compare_a,
    output logic irq_compare_b,
    output logic irq_capture
);
    stca_tick_if tif ();

    logic [7:0] temp_q, temp_d;
    logic [15:0] cnt_q, cnt_d;
    logic [15:0] cmpa_q, cmpa_d, cmpa_buf_q, cmpa_buf_d;
    logic [15:0] cmpb_q, cmpb_d, cmpb_buf_q, cmpb_buf_d;
    logic [15:0] cap_q, cap_d;
    logic [7:0] ctrl_a_q, ctrl_a_d, ctrl_b_q, ctrl_b_d;
    logic [7:0] mask_q, mask_d;
    logic [3:0] flg_q, flg_d;
    logic [7:0] rdata_d;
    logic [1:0] ext_s_q, cap_s_q, cmp_s_q;
    logic [`STCA_NC_LEN-1:0] nc_q, nc_d;
    logic cap_lvl_q, cap_lvl_d;
    logic cap_src, cap_edge;
    logic [3:0] wgm;
    logic [15:0] top;
    logic pwm_mode, top_from_a;
    logic cnt_wr, hit_a, hit_b, ovf_ev;

    function automatic logic wr_at(input logic [5:0] a, input logic [5:0] t);
        wr_at = io_wr && (a == t);
    endfunction : wr_at

    // shared prescaler and clock select
    assign tif.psr_clear = wr_at(io_addr, `STCA_ADR_SFIO) && io_wdata[`STCA_SFIO_PSR];
    assign tif.cs = ctrl_b_q[2:0];
    assign tif.ext_sync = ext_s_q[1];

    stca_tick_gen u_tick (
        .clk(clk),
        .reset_n(reset_n),
        .tif(tif)
    );

    // two-flop pin synchronisers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            ext_s_q <= 2'h0;
            cap_s_q <= 2'h0;
            cmp_s_q <= 2'h0;
        end else begin
            ext_s_q <= {ext_s_q[0], external_count_pin};
            cap_s_q <= {cap_s_q[0], capture_input_pin};
            cmp_s_q <= {cmp_s_q[0], comparator_out};
        end
    end

    // mode decode and top selection
    assign wgm = {ctrl_b_q[`STCA_CB_WGM3], ctrl_b_q[`STCA_CB_WGM2], ctrl_a_q[1:0]};
    assign pwm_mode = (wgm != 4'h0) && (wgm != 4'h4) && (wgm != 4'hC);
    assign top_from_a = (wgm == 4'h4) || (wgm == 4'h9) || (wgm == 4'hB) || (wgm == 4'hF);

    always_comb begin
        case (wgm)
            4'h1, 4'h5: top = `STCA_TOP8;
            4'h2, 4'h6: top = `STCA_TOP9;
            4'h3, 4'h7: top = `STCA_TOP10;
            4'h4, 4'h9, 4'hB, 4'hF: top = cmpa_q;
            4'h8, 4'hA, 4'hC, 4'hE: top = cap_q;
            default: top = `STCA_MAX;
        endcase
    end

    // boundaries and compare results
    assign at_bottom = (cnt_q == `STCA_BOTTOM);
    assign at_max = (cnt_q == `STCA_MAX);
    assign at_top = (cnt_q == top);
    assign hit_a = (cnt_q == cmpa_q);
    assign hit_b = (cnt_q == cmpb_q);
    assign cnt_wr = wr_at(io_addr, `STCA_ADR_CNT_L);
    assign ovf_ev = tif.tick && !cnt_wr && (at_top || at_max);

    // capture noise filter and edge
    assign cap_src = cmp_s_q[1];
    assign cap_edge = (cap_lvl_d != cap_lvl_q) && (cap_lvl_d == ctrl_b_q[`STCA_CB_ES]);

    always_comb begin
        nc_d = {nc_q[`STCA_NC_LEN-2:0], (ctrl_b_q[5] ? cap_src : cap_s_q[1])};
        cap_lvl_d = cap_lvl_q;
        if (!ctrl_b_q[`STCA_CB_NC]) begin
            cap_lvl_d = nc_d[0];
        end else if (&nc_q) begin
            cap_lvl_d = 1'b1;
        end else if (~|nc_q) begin
            cap_lvl_d = 1'b0;
        end
    end

    // register file next state
    always_comb begin
        temp_d = temp_q;
        cnt_d = cnt_q;
        cmpa_buf_d = cmpa_buf_q;
        cmpb_buf_d = cmpb_buf_q;
        cmpa_d = pwm_mode ? cmpa_q : cmpa_buf_q;
        cmpb_d = pwm_mode ? cmpb_q : cmpb_buf_q;
        cap_d = cap_q;
        ctrl_a_d = ctrl_a_q;
        ctrl_b_d = ctrl_b_q;
        mask_d = mask_q;
        flg_d = flg_q;
        // counting
        if (tif.tick) begin
            cnt_d = (at_top || at_max) ? `STCA_BOTTOM : cnt_q + 16'h0001;
            if (pwm_mode && at_top) begin
                cmpa_d = cmpa_buf_q;
                cmpb_d = cmpb_buf_q;
            end
        end
        // processor writes
        if (io_wr) begin
            case (io_addr)
                `STCA_ADR_CNT_H, `STCA_ADR_CMPA_H, `STCA_ADR_CMPB_H, `STCA_ADR_CAP_H: begin
                    temp_d = io_wdata;
                end
                `STCA_ADR_CNT_L: cnt_d = {temp_q, io_wdata};
                `STCA_ADR_CMPA_L: cmpa_buf_d = {temp_q, io_wdata};
                `STCA_ADR_CMPB_L: cmpb_buf_d = {temp_q, io_wdata};
                `STCA_ADR_CAP_L: cap_d = {temp_q, io_wdata};
                `STCA_ADR_CTRL_A: ctrl_a_d = io_wdata & 8'hF3;
                `STCA_ADR_CTRL_B: ctrl_b_d = io_wdata;
                `STCA_ADR_MASK: mask_d = io_wdata;
                `STCA_ADR_FLAG: begin
                    flg_d = flg_q & ~{io_wdata[`STCA_FLG_CAP], io_wdata[`STCA_FLG_CMPA],
                        io_wdata[`STCA_FLG_CMPB], io_wdata[`STCA_FLG_OVF]};
                end
                default: ;
            endcase
        end
        if (io_rd && (io_addr == `STCA_ADR_CNT_L)) begin
            temp_d = cnt_q[15:8];
        end else if (io_rd && (io_addr == `STCA_ADR_CAP_L)) begin
            temp_d = cap_q[15:8];
        end
        // hardware events win over clears
        if (cap_edge && !(wgm[3] && !wgm[0])) begin // no latch while capture holds top
            cap_d = cnt_q;
        end
        if (cap_edge) flg_d[3] = 1'b1;
        if (hit_a && tif.tick || wr_at(io_addr, `STCA_ADR_CTRL_A) && io_wdata[`STCA_CA_FOCA]) begin
            flg_d[2] = 1'b1;
        end
        if (hit_b && tif.tick || wr_at(io_addr, `STCA_ADR_CTRL_A) && io_wdata[`STCA_CA_FOCB]) begin
            flg_d[1] = 1'b1;
        end
        if (ovf_ev) flg_d[0] = 1'b1;
        if (cnt_wr) cnt_d = {temp_q, io_wdata};
    end

    // read data
    always_comb begin
        case (io_addr)
            `STCA_ADR_CNT_L: rdata_d = cnt_q[7:0];
            `STCA_ADR_CMPA_L: rdata_d = cmpa_buf_q[7:0];
            `STCA_ADR_CMPA_H: rdata_d = cmpa_buf_q[15:8];
            `STCA_ADR_CMPB_L: rdata_d = cmpb_buf_q[7:0];
            `STCA_ADR_CMPB_H: rdata_d = cmpb_buf_q[15:8];
            `STCA_ADR_CAP_L: rdata_d = cap_q[7:0];
            `STCA_ADR_CNT_H, `STCA_ADR_CAP_H: rdata_d = temp_q;
            `STCA_ADR_CTRL_A: rdata_d = ctrl_a_q;
            `STCA_ADR_CTRL_B: rdata_d = ctrl_b_q;
            `STCA_ADR_FLAG: rdata_d = {2'h0, flg_q[3], flg_q[2], flg_q[1], flg_q[0], 2'h0};
            `STCA_ADR_MASK: rdata_d = mask_q;
            `STCA_ADR_SFIO: rdata_d = 8'h00;
            default: rdata_d = 8'h00;
        endcase
    end

    // state registers
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            temp_q <= `STCA_RST_BYTE;
            cnt_q <= `STCA_RST_WORD;
            cmpa_q <= `STCA_RST_WORD;
            cmpb_q <= `STCA_RST_WORD;
            cmpa_buf_q <= `STCA_RST_WORD;
            cmpb_buf_q <= `STCA_RST_WORD;
            cap_q <= `STCA_RST_WORD;
            ctrl_a_q <= `STCA_RST_BYTE;
            ctrl_b_q <= `STCA_RST_BYTE;
            mask_q <= `STCA_RST_BYTE;
            flg_q <= 4'h0;
            nc_q <= '0;
            cap_lvl_q <= 1'b0;
            io_rdata <= 8'h00;
            match_a <= 1'b0;
            match_b <= 1'b0;
        end else begin
            temp_q <= temp_d;
            cnt_q <= cnt_d;
            cmpa_q <= cmpa_d;
            cmpb_q <= cmpb_d;
            cmpa_buf_q <= cmpa_buf_d;
            cmpb_buf_q <= cmpb_buf_d;
            cap_q <= cap_d;
            ctrl_a_q <= ctrl_a_d;
            ctrl_b_q <= ctrl_b_d;
            mask_q <= mask_d;
            flg_q <= flg_d;
            nc_q <= nc_d;
            cap_lvl_q <= cap_lvl_d;
            io_rdata <= rdata_d;
            match_a <= hit_a && !(pwm_mode && top_from_a);
            match_b <= hit_b;
        end
    end

    // masked interrupt requests
    assign irq_capture = flg_q[3] & mask_q[`STCA_FLG_CAP];
    assign irq_compare_a = flg_q[2] & mask_q[`STCA_FLG_CMPA];
    assign irq_compare_b = flg_q[1] & mask_q[`STCA_FLG_CMPB];
    assign irq_overflow = flg_q[0] & mask_q[`STCA_FLG_OVF];

    // bus, count and flag checks
    a_low_write_load: assert property (@(posedge clk) disable iff (!reset_n)
        io_wr && io_addr == `STCA_ADR_CNT_L |=> cnt_q == {$past(temp_q), $past(io_wdata)})
        else $error("counter low write wrong");
    a_high_write_temp: assert property (@(posedge clk) disable iff (!reset_n)
        io_wr && io_addr == `STCA_ADR_CMPB_H |=> temp_q == $past(io_wdata) && $stable(cmpb_buf_q))
        else $error("high write touched register");
    a_low_read_temp: assert property (@(posedge clk) disable iff (!reset_n)
        io_rd && !io_wr && io_addr == `STCA_ADR_CNT_L |=> temp_q == $past(cnt_q[15:8]))
        else $error("temp not loaded on read");
    a_sfio_reads_zero: assert property (@(posedge clk) disable iff (!reset_n)
        io_addr == `STCA_ADR_SFIO |=> io_rdata == 8'h00) else $error("sfio read nonzero");
    a_cmpa_high_read: assert property (@(posedge clk) disable iff (!reset_n)
        io_addr == `STCA_ADR_CMPA_H |=> io_rdata == $past(cmpa_buf_q[15:8]))
        else $error("compare high read via temp");
    a_stopped_count: assert property (@(posedge clk) disable iff (!reset_n)
        ctrl_b_q[2:0] == 3'h0 && !io_wr |=> $stable(cnt_q)) else $error("counter ran stopped");
    a_ovf_flag: assert property (@(posedge clk) disable iff (!reset_n)
        ovf_ev |=> flg_q[0]) else $error("overflow flag lost");
    a_cmpb_flag: assert property (@(posedge clk) disable iff (!reset_n)
        hit_b && tif.tick |=> flg_q[1]) else $error("compare b flag lost");
    a_cmpa_flag: assert property (@(posedge clk) disable iff (!reset_n)
        hit_a && tif.tick |=> flg_q[2]) else $error("compare a flag lost");
    a_cap_latch: assert property (@(posedge clk) disable iff (!reset_n)
        cap_edge && wgm == 4'h0 && !io_wr |=> cap_q == $past(cnt_q) && flg_q[3])
        else $error("capture missed");
    a_wrap_bottom: assert property (@(posedge clk) disable iff (!reset_n)
        tif.tick && at_max && wgm == 4'h0 && !cnt_wr |=> at_bottom) else $error("no wrap to bottom");
    a_top_wrap: assert property (@(posedge clk) disable iff (!reset_n)
        tif.tick && at_top && !cnt_wr |=> cnt_q == `STCA_BOTTOM) else $error("no restart after top");
    a_force_a_flag: assert property (@(posedge clk) disable iff (!reset_n)
        io_wr && io_addr == `STCA_ADR_CTRL_A && io_wdata[`STCA_CA_FOCA] |=> flg_q[2])
        else $error("force a ignored");
    a_force_b_flag: assert property (@(posedge clk) disable iff (!reset_n)
        io_wr && io_addr == `STCA_ADR_CTRL_A && io_wdata[`STCA_CA_FOCB] |=> flg_q[1])
        else $error("force b ignored");
    a_top_no_out: assert property (@(posedge clk) disable iff (!reset_n)
        pwm_mode && top_from_a |=> !match_a) else $error("top compare drove output");
endmodule : stca_timer

/* stca_cpu_model.sv */
module stca_cpu_model (
    // clock
    input wire logic clk,
    // io bus toward the timer
    output logic [5:0] io_addr,
    output logic io_wr,
    output logic io_rd,
    output logic [7:0] io_wdata
);
    timeunit 1ns;
    timeprecision 1ps;

    // bus idle before reset release
    initial begin
        io_addr = 6'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        io_wdata = 8'h00;
    end

    // one byte write, strobe held for a single edge
    task automatic wr8(input logic [5:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~d; // released data shows no stale byte
    endtask : wr8

    // one byte read, data lands one edge later
    task automatic rd8(input logic [5:0] a);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
    endtask : rd8

    // high byte first so the low write commits the word
    task automatic wr16(input logic [5:0] a, input logic [15:0] d);
        wr8(a + 6'h01, d[15:8]);
        wr8(a, d[7:0]);
    endtask : wr16

    // low byte first so a counter or capture high byte comes from temp
    task automatic rd16(input logic [5:0] a);
        rd8(a);
        rd8(a + 6'h01);
    endtask : rd16
endmodule : stca_cpu_model

/* stca_timer_tb_top.sv */
`include "stca_consts.svh"
module stca_timer_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic [5:0] io_addr;
    logic io_wr, io_rd;
    logic [7:0] io_wdata, io_rdata;
    logic ext_pin = 1'b0, cap_pin = 1'b0, cmp_out = 1'b0;
    logic match_a, match_b, at_bottom, at_max, at_top;
    logic irq_ovf, irq_a, irq_b, irq_cap;
    logic [8:0] notes [$];
    logic [8:0] note;
    logic rd_d = 1'b0;
    logic [15:0] last_word = 16'h0000;
    logic [15:0] v, exp_cap;
    logic [7:0] bit_v;
    logic [7:0] ctl [4] = '{8'h40, 8'h60, 8'hC0, 8'hC0};
    int len [4] = '{8, 8, 2, 8};
    int divs [4] = '{8, 64, 256, 1024};
    int num_errors = 0;
    int checked = 0;

    // 100 MHz clock
    always #5 clk = ~clk;

    stca_timer dut (.clk(clk), .reset_n(reset_n), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd),
        .io_wdata(io_wdata), .io_rdata(io_rdata), .external_count_pin(ext_pin),
        .capture_input_pin(cap_pin), .comparator_out(cmp_out), .match_a(match_a), .match_b(match_b),
        .at_bottom(at_bottom), .at_max(at_max), .at_top(at_top), .irq_overflow(irq_ovf),
        .irq_compare_a(irq_a), .irq_compare_b(irq_b), .irq_capture(irq_cap));

    stca_cpu_model cpu (.clk(clk), .io_addr(io_addr), .io_wr(io_wr), .io_rd(io_rd), .io_wdata(io_wdata));

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic close_out();
        $display("checked=%0d num_errors=%0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : close_out

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask : idle

    task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
        notes.push_back({1'b1, e});
        cpu.rd8(a);
    endtask : rd_exp

    task automatic rd16_exp(input logic [5:0] a, input logic [15:0] e, input logic chk);
        notes.push_back({chk, e[7:0]});
        notes.push_back({chk, e[15:8]});
        cpu.rd16(a);
    endtask : rd16_exp

    // read data is compared with the oldest note
    always @(posedge clk) rd_d <= io_rd;
    always @(negedge clk) begin
        if (rd_d && notes.size() > 0) begin
            last_word = {io_rdata, last_word[15:8]};
            note = notes.pop_front();
            if (note[8]) begin
                check({8'h00, io_rdata}, {8'h00, note[7:0]});
            end
        end
    end

    // hang guard
    initial begin
        idle(20000);
        num_errors++;
        $display("BAD t=%0t seen=%h exp=%h", $time, 1'b0, 1'b1);
        close_out();
    end

    // main sequence
    initial begin
        void'($urandom(32'h07CE1652));
        idle(10);
        reset_n <= 1'b1;
        @(negedge clk);
        check({15'h0000, at_bottom}, 16'h0001);
        cpu.wr8(6'h3F, 8'hFF);
        for (int a = 0; a <= 13; a++) begin
            rd_exp(a[5:0], 8'h00);
        end
        rd_exp(6'h3F, 8'h00);
        // random words through counter and both compares
        for (int i = 0; i < 3; i++) begin
            v = 16'($urandom);
            cpu.wr16(6'(2 * i), v);
            rd16_exp(6'(2 * i), v, 1'b1);
        end
        cpu.wr16(`STCA_ADR_CNT_L, 16'hFFFF);
        @(negedge clk);
        check({13'h0000, at_top, at_max, at_bottom}, 16'h0006);
        // high write alone keeps target, temp is shared
        cpu.wr16(`STCA_ADR_CNT_L, 16'h1111);
        cpu.wr8(`STCA_ADR_CNT_H, 8'h99);
        rd16_exp(`STCA_ADR_CNT_L, 16'h1111, 1'b1);
        cpu.wr8(`STCA_ADR_CMPA_H, 8'hAB);
        cpu.wr8(`STCA_ADR_CNT_L, 8'hCD);
        rd16_exp(`STCA_ADR_CNT_L, 16'hABCD, 1'b1);
        cpu.wr16(`STCA_ADR_CMPA_L, 16'h5A3C);
        cpu.wr8(`STCA_ADR_CNT_H, 8'h77);
        rd_exp(`STCA_ADR_CMPA_H, 8'h5A);
        rd_exp(`STCA_ADR_CNT_H, 8'h77);
        // counter equal to compare A only
        cpu.wr16(`STCA_ADR_CMPB_L, 16'h1234);
        cpu.wr16(`STCA_ADR_CNT_L, 16'h5A3C);
        idle(1);
        @(negedge clk);
        check({14'h0000, match_a, match_b}, 16'h0002);
        // prescaler reset bit, one and zero
        for (int k = 0; k < 2; k++) begin
            cpu.wr8(`STCA_ADR_SFIO, 8'(1 - k));
            rd_exp(`STCA_ADR_SFIO, 8'h00);
        end
        cpu.wr8(`STCA_ADR_CTRL_B, 8'h58);
        rd_exp(`STCA_ADR_CTRL_B, 8'h58);
        cpu.wr8(`STCA_ADR_CTRL_A, 8'h0F);
        rd_exp(`STCA_ADR_CTRL_A, 8'h03);
        cpu.wr8(`STCA_ADR_CTRL_A, 8'h00);
        cpu.wr8(`STCA_ADR_CTRL_B, 8'h00);
        // forced compares set, mask and clear each flag
        for (int ch = 0; ch < 2; ch++) begin
            bit_v = 8'h10 >> ch;
            cpu.wr8(`STCA_ADR_FLAG, 8'h3C);
            cpu.wr8(`STCA_ADR_CTRL_A, 8'h08 >> ch);
            rd_exp(`STCA_ADR_FLAG, bit_v);
            cpu.wr8(`STCA_ADR_MASK, bit_v);
            @(negedge clk);
            check({14'h0000, irq_a, irq_b}, {14'h0000, 2'b10 >> ch});
            cpu.wr8(`STCA_ADR_FLAG, bit_v);
            @(negedge clk);
            check({14'h0000, irq_a, irq_b}, 16'h0000);
        end
        // free run through both matches and the wrap
        cpu.wr16(`STCA_ADR_CMPA_L, 16'hFFF8);
        cpu.wr16(`STCA_ADR_CMPB_L, 16'hFFFC);
        cpu.wr16(`STCA_ADR_CNT_L, 16'hFFF0);
        cpu.wr8(`STCA_ADR_FLAG, 8'h3C);
        cpu.wr8(`STCA_ADR_MASK, 8'h3C);
        cpu.wr8(`STCA_ADR_CTRL_B, 8'h01);
        idle(40);
        cpu.wr8(`STCA_ADR_CTRL_B, 8'h00);
        rd_exp(`STCA_ADR_FLAG, 8'h1C);
        @(negedge clk);
        check({12'h000, irq_cap, irq_a, irq_b, irq_ovf}, 16'h0007);
        cpu.wr8(`STCA_ADR_FLAG, 8'h3C);
        cpu.wr8(`STCA_ADR_MASK, 8'h00);
        cpu.wr16(`STCA_ADR_CNT_L, 16'h4321);
        idle(50);
        rd16_exp(`STCA_ADR_CNT_L, 16'h4321, 1'b1);
        // external pin, falling then rising edge counting
        for (int m = 6; m < 8; m++) begin
            ext_pin <= (m == 6);
            idle(4);
            cpu.wr16(`STCA_ADR_CNT_L, 16'h0000);
            cpu.wr8(`STCA_ADR_CTRL_B, 8'(m));
            repeat (5) begin
                ext_pin <= (m == 7);
                idle(4);
                ext_pin <= (m == 6);
                idle(4);
            end
            idle(6);
            cpu.wr8(`STCA_ADR_CTRL_B, 8'h00);
            rd16_exp(`STCA_ADR_CNT_L, 16'h0005, 1'b1);
        end
        // capture from pin, comparator, filtered short and long pulses
        cpu.wr8(`STCA_ADR_MASK, 8'h20);
        for (int c = 0; c < 4; c++) begin
            v = 16'h1000 * c + 16'h0123;
            cpu.wr8(`STCA_ADR_FLAG, 8'h3C);
            cpu.wr16(`STCA_ADR_CNT_L, v);
            cpu.wr8(`STCA_ADR_CTRL_B, ctl[c]);
            cmp_out <= (c == 1);
            cap_pin <= (c != 1);
            idle(len[c]);
            cap_pin <= 1'b0;
            cmp_out <= 1'b0;
            idle(10);
            exp_cap = (c == 2) ? exp_cap : v;
            rd16_exp(`STCA_ADR_CAP_L, exp_cap, 1'b1);
            rd_exp(`STCA_ADR_FLAG, (c == 2) ? 8'h00 : 8'h20);
            @(negedge clk);
            check({15'h0000, irq_cap}, {15'h0000, c != 2});
        end
        // prescaled taps after a prescaler reset
        for (int k = 0; k < 4; k++) begin
            cpu.wr8(`STCA_ADR_CTRL_B, 8'h00);
            cpu.wr16(`STCA_ADR_CNT_L, 16'h0000);
            cpu.wr8(`STCA_ADR_SFIO, 8'h01);
            cpu.wr8(`STCA_ADR_CTRL_B, 8'(k + 2));
            idle(4 * divs[k] - 2);
            cpu.wr8(`STCA_ADR_CTRL_B, 8'h00);
            rd16_exp(`STCA_ADR_CNT_L, 16'h0000, 1'b0);
            idle(2);
            check(last_word, 16'h0004);
        end
        idle(4);
        if (notes.size() != 0) begin
            num_errors++;
        end
        close_out();
    end
endmodule : stca_timer_tb_top
